// ---- logic/output_compare_pwm_channel.sv ----
// output compare channel with pulse, level and pwm modes plus time bases
//
// How it works
// - continuous pulse mode starts low, then pulses on each match pair.
// - writing a pulse mode drives the pin low at once.
// - primary compare match drives the pin high.
// - secondary compare match drives the pin back low.
// - pulse modes flag the channel event on the secondary match that ends a pulse.
// - time base wraps to zero on period match and keeps counting.
// - pwm modes make the primary register a read-only active duty.
// - primary value at enable is the duty of the first period.
// - secondary takes writes anytime, copied to duty on period match.
// - period value N gives N plus one counts per period.
// - duty zero keeps the pin low all period.
// - duty above period keeps the pin high.
// - duty equal to period gives one low count per period.
// - control bit 13 halts the channel while the cpu idles.
// - status bit 4 flags a pwm fault, cleared by hardware only.
// - control bit 3 picks the third timer, else the second.
// - code 111 is pwm with fault, 110 pwm ignoring fault.
// - code 011 toggles the pin on each compare match.
// - code 010 starts the pin high and clears it on match.
// - code 001 starts the pin low and sets it on match.
// - code 100 gives one pulse only, code 000 disables.
// - after a single pulse the pin stays low until rewritten.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
module output_compare_pwm_channel
  import compare_channel_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [2:0]  i_address,
  input  wire logic [15:0] i_write_data,
  input  wire logic        i_write_strobe,
  input  wire logic        i_read_strobe,
  input  wire logic        i_cpu_idle,
  input  wire logic        i_pwm_fault,
  output logic      [15:0] o_read_data,
  output logic             o_compare_output_pin,
  output logic             o_channel_interrupt_flag
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  channel_state_t st;
  channel_state_t next_st;

  logic [15:0] count2;
  logic [15:0] count3;
  logic        period_match2;
  logic        period_match3;
  logic [15:0] sel_count;
  logic [15:0] sel_period;
  logic        sel_run;
  logic        sel_period_match;
  logic        halted;
  logic        pwm_mode;
  logic        pri_match;
  logic        sec_match;
  logic        fault_event;
  logic        wr_ctrl;
  logic [2:0]  wr_mode;
  logic [15:0] ctrl_word;
  logic [15:0] run_word;

  // ----------------------------------------------------------------
  // the two time bases
  // ----------------------------------------------------------------
  time_base u_time_base2 (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_run          (st.run2),
    .i_period       (st.period2),
    .o_count        (count2),
    .o_period_match (period_match2)
  );

  time_base u_time_base3 (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_run          (st.run3),
    .i_period       (st.period3),
    .o_count        (count3),
    .o_period_match (period_match3)
  );

  // ----------------------------------------------------------------
  // match decode
  // ----------------------------------------------------------------
  // a stopped time base never matches, so toggles cannot chatter
  always_comb begin
    sel_count        = st.select ? count3 : count2;
    sel_period       = st.select ? st.period3 : st.period2;
    sel_run          = st.select ? st.run3 : st.run2;
    sel_period_match = st.select ? period_match3 : period_match2;
    halted           = st.idle_halt && i_cpu_idle;
    pwm_mode         = (st.mode == MODE_PWM_FREE) ||
                       (st.mode == MODE_PWM_FAULT);
    pri_match        = sel_run && (sel_count == st.primary);
    sec_match        = sel_run && (sel_count == st.secondary);
    fault_event      = !halted && (st.mode == MODE_PWM_FAULT) &&
                       i_pwm_fault;
    wr_ctrl          = i_write_strobe && (i_address == ADDR_CONTROL);
    wr_mode          = i_write_data[MODE_MSB:MODE_LSB];
  end

  // readable words, unused bits read as zero
  always_comb begin
    ctrl_word                     = RST_WORD;
    ctrl_word[BIT_IDLE_HALT]      = st.idle_halt;
    ctrl_word[BIT_FAULT]          = st.fault;
    ctrl_word[BIT_SELECT]         = st.select;
    ctrl_word[MODE_MSB:MODE_LSB]  = st.mode;
    run_word                      = RST_WORD;
    run_word[BIT_RUN2]            = st.run2;
    run_word[BIT_RUN3]            = st.run3;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.irq   = 1'b0;
    next_st.rdata = RST_WORD;

    // read data stand only in the cycle after the strobe
    if (i_read_strobe) begin
      unique case (i_address)
        ADDR_CONTROL:   next_st.rdata = ctrl_word;
        ADDR_PRIMARY:   next_st.rdata = st.primary;
        ADDR_SECONDARY: next_st.rdata = st.secondary;
        ADDR_PERIOD2:   next_st.rdata = st.period2;
        ADDR_PERIOD3:   next_st.rdata = st.period3;
        ADDR_TIMER_RUN: next_st.rdata = run_word;
        ADDR_COUNT2:    next_st.rdata = count2;
        ADDR_COUNT3:    next_st.rdata = count3;
      endcase
    end

    // channel behaviour, frozen as a whole while halted in idle
    if (!halted) begin
      unique case (st.mode)
        MODE_SET_HIGH: begin
          if (pri_match) begin
            next_st.pin = 1'b1;
            next_st.irq = 1'b1;
          end
        end
        MODE_FORCE_LOW: begin
          if (pri_match) begin
            next_st.pin = 1'b0;
            next_st.irq = 1'b1;
          end
        end
        MODE_TOGGLE: begin
          if (pri_match) begin
            next_st.pin = ~st.pin;
            next_st.irq = 1'b1;
          end
        end
        MODE_SINGLE, MODE_CONTINUOUS: begin
          unique case (st.pulse)
            PULSE_RISE: begin
              if (pri_match) begin
                next_st.pin   = 1'b1;
                next_st.pulse = PULSE_FALL;
              end
            end
            PULSE_FALL: begin
              if (sec_match) begin
                next_st.pin = 1'b0;
                next_st.irq = 1'b1;
                if (st.mode == MODE_CONTINUOUS) begin
                  next_st.pulse = PULSE_RISE;
                end else begin
                  next_st.pulse = PULSE_DONE;
                end
              end
            end
            PULSE_IDLE, PULSE_DONE: begin
              next_st.pin = 1'b0;
            end
            default: begin
              next_st.pulse = PULSE_IDLE;
            end
          endcase
        end
        MODE_PWM_FREE, MODE_PWM_FAULT: begin
          // the flag sticks until the mode is written again
          if (fault_event) begin
            next_st.fault = 1'b1;
          end
          // high while count is below duty covers 0 %, 100 % and N
          if (next_st.fault && (st.mode == MODE_PWM_FAULT)) begin
            next_st.pin = 1'b0;
          end else begin
            next_st.pin = (sel_count < st.primary);
          end
          // double buffer: duty only moves at a period boundary
          if (sel_period_match) begin
            next_st.primary = st.secondary;
            next_st.irq     = 1'b1;
          end
        end
        default: begin
          next_st.pin = 1'b0;
        end
      endcase
    end

    // software writes
    if (i_write_strobe) begin
      unique case (i_address)
        ADDR_CONTROL: begin
          next_st.idle_halt = i_write_data[BIT_IDLE_HALT];
          next_st.select    = i_write_data[BIT_SELECT];
          next_st.mode      = wr_mode;
          // hardware clears the flag here, a fresh fault still wins
          next_st.fault     = fault_event;
          next_st.pulse     = PULSE_IDLE;
          unique case (wr_mode)
            MODE_SINGLE, MODE_CONTINUOUS: begin
              next_st.pin   = 1'b0;
              next_st.pulse = PULSE_RISE;
            end
            MODE_FORCE_LOW: begin
              next_st.pin = 1'b1;
            end
            MODE_PWM_FREE, MODE_PWM_FAULT: begin
              // keep pin; primary already holds the first duty
              next_st.pin = next_st.pin;
            end
            default: begin
              next_st.pin = 1'b0;
            end
          endcase
        end
        ADDR_PRIMARY: begin
          if (!pwm_mode) begin
            next_st.primary = i_write_data;
          end
        end
        ADDR_SECONDARY: next_st.secondary = i_write_data;
        ADDR_PERIOD2:   next_st.period2   = i_write_data;
        ADDR_PERIOD3:   next_st.period3   = i_write_data;
        ADDR_TIMER_RUN: begin
          next_st.run2 = i_write_data[BIT_RUN2];
          next_st.run3 = i_write_data[BIT_RUN3];
        end
        default: begin
          next_st.rdata = next_st.rdata;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '{idle_halt: 1'b0, select: 1'b0, mode: RST_MODE,
             fault: 1'b0, primary: RST_WORD, secondary: RST_WORD,
             period2: RST_WORD, period3: RST_WORD, run2: 1'b0,
             run3: 1'b0, pin: 1'b0, irq: 1'b0, rdata: RST_WORD,
             pulse: PULSE_IDLE};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign o_read_data              = st.rdata;
  assign o_compare_output_pin     = st.pin;
  assign o_channel_interrupt_flag = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_rise_event;
    !halted && !wr_ctrl && st.pulse == PULSE_RISE && pri_match &&
    (st.mode == MODE_SINGLE || st.mode == MODE_CONTINUOUS);
  endsequence

  sequence s_fall_event;
    !halted && !wr_ctrl && st.pulse == PULSE_FALL && sec_match &&
    (st.mode == MODE_SINGLE || st.mode == MODE_CONTINUOUS);
  endsequence

  sequence s_pwm_run;
    !halted && !wr_ctrl && pwm_mode && !st.fault && !fault_event;
  endsequence

  chk_pulse_rise_high: assert property (
    s_rise_event |=> st.pin && st.pulse == PULSE_FALL)
    else $error("pin not raised on primary match");

  chk_pulse_fall_flag: assert property (
    s_fall_event |=> !st.pin && o_channel_interrupt_flag)
    else $error("fall edge or flag missing on secondary match");

  chk_continuous_repeat: assert property (
    s_fall_event and (st.mode == MODE_CONTINUOUS)
    |=> st.pulse == PULSE_RISE)
    else $error("continuous mode did not rearm");

  chk_single_stays_low: assert property (
    s_fall_event and (st.mode == MODE_SINGLE)
    |=> (!st.pin && st.pulse == PULSE_DONE) ##1
        ($past(wr_ctrl) || !st.pin))
    else $error("single pulse did not stay low");

  chk_pulse_mode_low: assert property (
    wr_ctrl && (wr_mode == MODE_SINGLE || wr_mode == MODE_CONTINUOUS)
    |=> !o_compare_output_pin && st.pulse == PULSE_RISE)
    else $error("pulse mode write did not drive pin low");

  chk_toggle_inverts: assert property (
    !halted && !wr_ctrl && st.mode == MODE_TOGGLE && pri_match
    |=> st.pin != $past(st.pin))
    else $error("toggle mode did not invert pin");

  chk_duty_reload: assert property (
    !halted && !wr_ctrl && pwm_mode && sel_period_match
    |=> st.primary == $past(st.secondary))
    else $error("duty not reloaded at period match");

  chk_primary_locked: assert property (
    pwm_mode && !sel_period_match &&
    i_write_strobe && i_address == ADDR_PRIMARY
    |=> st.primary == $past(st.primary))
    else $error("primary changed by a write in pwm mode");

  chk_duty_zero_low: assert property (
    s_pwm_run and (st.primary == RST_WORD) |=> !st.pin)
    else $error("zero duty drove the pin high");

  chk_duty_full_high: assert property (
    s_pwm_run and (st.primary > sel_period) and
    (sel_count <= sel_period) |=> st.pin)
    else $error("duty above period let the pin fall");

  chk_duty_equal_one: assert property (
    s_pwm_run and (st.primary == sel_period)
    |=> st.pin == ($past(sel_count) != $past(sel_period)))
    else $error("duty equal to period gave wrong low count");

  chk_fault_hold_low: assert property (
    fault_event && !wr_ctrl |=> (!st.pin && st.fault) and
    (!wr_ctrl ##1 !wr_ctrl |=> !st.pin && st.fault))
    else $error("fault did not hold pin low");

  chk_idle_freeze: assert property (
    halted && !wr_ctrl |=> st.pin == $past(st.pin) &&
    st.pulse == $past(st.pulse))
    else $error("channel moved while halted in idle");

  chk_timer_wrap: assert property (
    st.run2 && count2 == st.period2 |=> count2 == RST_WORD)
    else $error("time base did not wrap to zero");

endmodule // output_compare_pwm_channel

// ---- logic/compare_channel_pkg.sv ----
// constants and state types for the output compare channel
package compare_channel_pkg;

  // ----------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_PRIMARY   = 3'h1;
  localparam logic [2:0] ADDR_SECONDARY = 3'h2;
  localparam logic [2:0] ADDR_PERIOD2   = 3'h3;
  localparam logic [2:0] ADDR_PERIOD3   = 3'h4;
  localparam logic [2:0] ADDR_TIMER_RUN = 3'h5;
  localparam logic [2:0] ADDR_COUNT2    = 3'h6;
  localparam logic [2:0] ADDR_COUNT3    = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_FAULT     = 4;
  localparam int BIT_SELECT    = 3;
  localparam int MODE_MSB      = 2;
  localparam int MODE_LSB      = 0;
  localparam int BIT_RUN2      = 0;
  localparam int BIT_RUN3      = 1;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_MODE = 3'h0;

  // ----------------------------------------------------------------
  // compare mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF        = 3'h0;
  localparam logic [2:0] MODE_SET_HIGH   = 3'h1;
  localparam logic [2:0] MODE_FORCE_LOW  = 3'h2;
  localparam logic [2:0] MODE_TOGGLE     = 3'h3;
  localparam logic [2:0] MODE_SINGLE     = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h5;
  localparam logic [2:0] MODE_PWM_FREE   = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT  = 3'h7;

  // pulse sequencer, one-hot
  typedef enum logic [3:0] {
    PULSE_IDLE = 4'h1,
    PULSE_RISE = 4'h2,
    PULSE_FALL = 4'h4,
    PULSE_DONE = 4'h8
  } pulse_state_t;

  typedef struct packed {
    logic [15:0] count;
  } time_base_state_t;

  typedef struct packed {
    logic         idle_halt;
    logic         select;
    logic [2:0]   mode;
    logic         fault;
    logic [15:0]  primary;
    logic [15:0]  secondary;
    logic [15:0]  period2;
    logic [15:0]  period3;
    logic         run2;
    logic         run3;
    logic         pin;
    logic         irq;
    logic [15:0]  rdata;
    pulse_state_t pulse;
  } channel_state_t;

endpackage

// ---- logic/time_base.sv ----
// one 16-bit time base that wraps at its period value
`timescale 1ns/1ns
module time_base
  import compare_channel_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  input  wire logic [15:0] i_period,
  output logic      [15:0] o_count,
  output logic             o_period_match
);

  time_base_state_t st;
  time_base_state_t next_st;

  // --------------------------------------------------------------
  // counting
  // --------------------------------------------------------------
  // count of N wraps to zero, so one period spans N plus one counts
  always_comb begin
    next_st = st;
    if (i_run) begin
      if (st.count == i_period) begin
        next_st.count = RST_WORD;
      end else begin
        next_st.count = st.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '{count: RST_WORD};
    end else begin
      st <= next_st;
    end
  end

  // match only while running, a stopped timer must not retrigger
  assign o_count        = st.count;
  assign o_period_match = i_run && (st.count == i_period);

endmodule // time_base

// ---- test/pin_load_model.sv ----
// pin load and fault source facing the compare channel
`timescale 1ns/1ns
module pin_load_model (
  input  wire logic        i_clk,
  input  wire logic        i_pin,
  input  wire logic        i_clear,
  input  wire logic        i_fault_cmd,
  output logic             o_fault,
  output logic      [15:0] o_rises,
  output logic      [15:0] o_high_len,
  output logic      [15:0] o_low_len
);
  logic        last;
  logic [15:0] run;

  // ----------------------------------------------------------------
  // run-length meter
  // ----------------------------------------------------------------
  // lengths are taken at each level change, so phase never matters
  initial begin
    o_fault = 1'b0;
    last = 1'b0;
    run = 16'h0000;
    o_rises = 16'h0000;
  end

  // fault is a synchronous level, moved only on the clock edge
  always @(posedge i_clk) begin
    o_fault <= i_fault_cmd;
    last <= i_pin;
    run <= (i_pin !== last) ? 16'h0001 : run + 16'h0001;
    if (i_pin !== last && last === 1'b1) o_high_len <= run;
    if (i_pin !== last && last === 1'b0) o_low_len <= run;
    if (i_pin === 1'b1 && last === 1'b0) o_rises <= o_rises + 16'h0001;
    // clear keeps run so a pulse spanning it is still measured
    if (i_clear) begin
      o_rises <= 16'h0000;
      o_high_len <= 16'h0000;
      o_low_len <= 16'h0000;
    end
  end
endmodule // pin_load_model

// ---- test/tb_output_compare_pwm_channel.sv ----
// self-checking bench for the output compare channel
`timescale 1ns/1ns
module tb_output_compare_pwm_channel;
  import compare_channel_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        ws = 1'b0;
  logic        rs = 1'b0;
  logic        idle = 1'b0;
  logic        fault_cmd = 1'b0;
  logic        clr = 1'b0;
  logic        rd_seen = 1'b0;
  logic        fault;
  logic        pin;
  logic        flag;
  logic [15:0] rdata;
  logic [15:0] rises;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] flags = 16'h0000;
  logic [15:0] expq[$];
  logic [15:0] duty[4] = '{16'h0000, 16'h0007, 16'h0009, 16'h0000};
  int          fails = 0;
  int          compares = 0;
  int          seed = 47950;

  always #20 clk = ~clk;

  output_compare_pwm_channel output_compare_pwm_channel_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_address(addr),
    .i_write_data(wdata), .i_write_strobe(ws), .i_read_strobe(rs),
    .i_cpu_idle(idle), .i_pwm_fault(fault), .o_read_data(rdata),
    .o_compare_output_pin(pin), .o_channel_interrupt_flag(flag));

  pin_load_model pin_load_model_inst (
    .i_clk(clk), .i_pin(pin), .i_clear(clr), .i_fault_cmd(fault_cmd),
    .o_fault(fault), .o_rises(rises), .o_high_len(hi), .o_low_len(lo));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one idle cycle after each strobe, so no strobe is set twice at once
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rs <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rs <= 1'b0;
  endtask

  // clear the meters, then watch n edges
  task automatic win(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, expq.pop_front());
    rd_seen <= rs;
    if (clr) flags <= 16'h0000;
    else if (flag === 1'b1) flags <= flags + 16'h0001;
  end

  // hang guard, far above the roughly 730 cycles of the run
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), RST_WORD);
    wr(ADDR_COUNT2, 16'hFFFF);
    rd(ADDR_COUNT2, 16'h0000);
    wr(ADDR_CONTROL, 16'hFFFF);
    rd(ADDR_CONTROL, 16'h200F);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_PERIOD2, 16'h0007);
    wr(ADDR_PERIOD3, 16'h000B);
    wr(ADDR_PRIMARY, 16'h0002);
    wr(ADDR_SECONDARY, 16'h0005);
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_CONTROL, 16'(m));
      chk({15'h0, pin}, 16'(m - 1));
      wr(ADDR_TIMER_RUN, 16'h0001);
      win(12);
      chk({15'h0, pin}, 16'(2 - m));
      wr(ADDR_TIMER_RUN, 16'h0000);
    end
    wr(ADDR_CONTROL, 16'h0003);
    wr(ADDR_TIMER_RUN, 16'h0001);
    win(30);
    chk(hi, 16'h0008);
    chk(lo, 16'h0008);
    wr(ADDR_TIMER_RUN, 16'h0000);
    wr(ADDR_CONTROL, 16'h0005);
    chk({15'h0, pin}, 16'h0000);
    wr(ADDR_TIMER_RUN, 16'h0001);
    repeat (40) begin
      @(posedge clk);
      if (flag === 1'b1) break;
    end
    win(19);
    chk(rises, 16'h0002);
    chk(flags, 16'h0002);
    chk(hi, 16'h0003);
    chk(lo, 16'h0005);
    @(posedge clk);
    idle <= 1'b1;
    wr(ADDR_CONTROL, 16'h2005);
    win(30);
    chk(rises, 16'h0000);
    wr(ADDR_CONTROL, 16'h0005);
    win(30);
    chk({15'h0, rises != 16'h0000}, 16'h0001);
    idle <= 1'b0;
    wr(ADDR_CONTROL, 16'h0004);
    win(40);
    chk(rises, 16'h0001);
    chk(flags, 16'h0001);
    chk(hi, 16'h0003);
    wr(ADDR_CONTROL, 16'h0004);
    win(40);
    chk(rises, 16'h0001);
    wr(ADDR_CONTROL, 16'h0000);
    win(20);
    chk(rises | flags, 16'h0000);
    wr(ADDR_CONTROL, 16'h000D);
    wr(ADDR_TIMER_RUN, 16'h0002);
    win(50);
    chk(lo, 16'h0009);
    // second reset so the time base restarts from zero for the pwm part
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(ADDR_PERIOD2, 16'h0007);
    wr(ADDR_PRIMARY, 16'h0002);
    wr(ADDR_SECONDARY, 16'h0005);
    wr(ADDR_CONTROL, 16'h0006);
    wr(ADDR_TIMER_RUN, 16'h0001);
    // pin already high while stopped at zero, so judge the low part
    win(9);
    chk(lo, 16'h0006);
    wr(ADDR_PRIMARY, 16'h0006);
    win(30);
    rd(ADDR_PRIMARY, 16'h0005);
    chk(hi, 16'h0005);
    chk(lo, 16'h0003);
    duty[3] = 16'(1 + $unsigned($random(seed)) % 6);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SECONDARY, duty[k]);
      win(20);
      win(24);
      if (duty[k] == 16'h0000 || duty[k] > 16'h0007) begin
        chk(rises, 16'h0000);
        chk({15'h0, pin}, {15'h0, duty[k] != 16'h0000});
      end else begin
        chk(hi, duty[k]);
        chk(lo, 16'h0008 - duty[k]);
      end
    end
    wr(ADDR_SECONDARY, 16'h0004);
    wr(ADDR_CONTROL, 16'h0007);
    @(posedge clk);
    fault_cmd <= 1'b1;
    @(posedge clk);
    fault_cmd <= 1'b0;
    win(20);
    chk(rises | {15'h0, pin}, 16'h0000);
    rd(ADDR_CONTROL, 16'h0017);
    wr(ADDR_CONTROL, 16'h0007);
    rd(ADDR_CONTROL, 16'h0007);
    win(20);
    chk({15'h0, rises != 16'h0000}, 16'h0001);
    wr(ADDR_CONTROL, 16'h0006);
    @(posedge clk);
    fault_cmd <= 1'b1;
    win(20);
    chk({15'h0, rises != 16'h0000}, 16'h0001);
    rd(ADDR_CONTROL, 16'h0006);
    fault_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    report_and_stop;
  end
endmodule // tb_output_compare_pwm_channel
